// ---- logic/aas_sequencer.sv ----
// Purpose: Anti-theft arm, disarm, relock and alarm sequencer
// Assumes: Remote commands are levels held for several ms
// Notes:   Retained state comes back on nv_* after power return
`timescale 1ns/1ps

// Notes on behaviour
// - Entry opened in relock window cancels relock
// - Window expiry locks, flashes, then arms
// - Unlock disarms, two flashes, unlocks doors
// - Key in and ignition on disarms
// - No key or entry: relock, flash, rearm
// - Unlock with entry open: no relock window
// - Repeat unlock restarts the relock window
// - Unlock, key and ignition, or an opened entry leaves armed state
// - Each repeat unlock flashes twice, unlocks
// - General alarm 30 s; China/Japan three cycles
// - Horn and hazard share identical timing
// - Alarm runs full period; reopen after the period retriggers
// - Europe/Australia alarm lasts 27 s
// - Remote lock or unlock clears alarm
// - Remote trunk open restarts a running alarm
// - Ignition on 30 s clears alarm, inhibit
// - Ignition off before 30 s: alarm continues
// - Power return mid-alarm: inhibit, three more cycles
// - EC/Australia power return: horn only once
// - Power return while armed restores armed
// - Lock, all closed: 30 s quiet, then arm
// - Lock with entry open: lock only
// - Remote lock, relock expiry or power return arms
module aas_sequencer
  import aas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Remote keyless receiver
  input  wire aas_rkc_t   remote_keyless_command,
  // Ignition key switch
  input  wire logic       key_in,
  input  wire logic       ign_on,
  // Entry switches, high when open
  input  wire aas_entry_t entry_open,
  // Market variant and retained state
  input  wire logic [1:0] region,
  input  wire logic       nv_armed,
  input  wire logic       nv_alarm,
  // Actuators and lamps
  output logic            door_lock,
  output logic            door_unlock,
  output logic            hazard,
  output logic            horn,
  output logic            start_inhibit,
  output logic            armed,
  // Retained state to backup store
  output logic            retain_armed,
  output logic            retain_alarm
);

  localparam int SW = 3 + 3 + 2 + 2 + 2;

  logic [SW-1:0] sync_q;
  aas_rkc_t      rkc_s;
  aas_entry_t    ent_s;
  logic          key_s;
  logic          ign_s;
  logic [1:0]    region_s;
  logic          nv_armed_s;
  logic          nv_alarm_s;
  logic          tick;

  aas_sync #(.W(SW)) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    ({remote_keyless_command, entry_open, key_in, ign_on,
            region, nv_armed, nv_alarm}),
    .q    (sync_q)
  );

  assign {rkc_s, ent_s, key_s, ign_s, region_s, nv_armed_s, nv_alarm_s} = sync_q;

  aas_timebase #(.CYC(TICK_CYCLES)) u_tb (
    .mclk (mclk),
    .rstn (rstn),
    .tick (tick)
  );

  // State and registers
  aas_state_t     state;
  aas_state_t     next_state;
  aas_rkc_t       rkc_q;
  aas_entry_t     ent_q;
  aas_region_t    reg_v;
  logic [1:0]     boot_cnt;
  logic [TMR_W-1:0] win_tmr;
  logic [TMR_W-1:0] ign_tmr;
  logic [TMR_W-1:0] alm_tmr;
  logic [TMR_W-1:0] alm_period;
  logic [1:0]     alm_lim;
  logic [1:0]     alm_cyc;
  logic [3:0]     alm_ph;
  logic           alm_on;
  logic [1:0]     flash_left;
  logic [3:0]     flash_ph;
  logic           haz_f;

  // Combinational controls
  logic       tmr_clr;
  logic       go_lock;
  logic       go_unlock;
  logic [1:0] flash_n;
  logic       alm_go;
  logic       alm_bat;
  logic       inh_set;
  logic       inh_clr;

  wire aas_rkc_t rkc_rise   = rkc_s & ~rkc_q;
  wire       any_open   = |ent_s;
  wire       open_rise  = |(ent_s & ~ent_q);
  wire       ent_chg    = (ent_s != ent_q);
  wire       remote_ok  = ~key_s;
  wire       lock_ev    = rkc_rise.lock & remote_ok;
  wire       unlock_ev  = rkc_rise.unlock & remote_ok;
  wire       trunk_ev   = rkc_rise.trunk;
  wire       key_ign    = key_s & ign_s;
  wire       win_end    = (win_tmr >= WIN_TK);
  wire       ign_clear  = (ign_tmr >= IGN_TK);
  wire       alm_ph_end = tick & (alm_ph == ALM_PH_TK - 4'h1);
  wire       in_alarm   = (state == S_ALARM) | (state == S_ADONE);
  wire       alm_end    = (alm_tmr >= alm_period) |
                          ((alm_lim != CYC_NONE) & (alm_cyc >= alm_lim));
  wire       boot_done  = (boot_cnt == BOOT_CYC);
  wire       flash_end  = tick & (flash_ph == FLASH_TK - 4'h1);

  always_comb begin
    next_state = state;
    tmr_clr    = 1'b0;
    go_lock    = 1'b0;
    go_unlock  = 1'b0;
    flash_n    = 2'h0;
    alm_go     = 1'b0;
    alm_bat    = 1'b0;
    inh_set    = 1'b0;
    inh_clr    = 1'b0;
    if (state == S_BOOT) begin
      if (boot_done) begin
        if (nv_alarm_s) begin
          next_state = S_ALARM;
          alm_go     = 1'b1;
          alm_bat    = 1'b1;
          inh_set    = 1'b1;
        end else if (nv_armed_s) begin
          next_state = S_ARMED;
        end else begin
          next_state = S_IDLE;
        end
      end
    end else if (unlock_ev) begin
      go_unlock = 1'b1;
      flash_n   = 2'h2;
      tmr_clr   = 1'b1;
      next_state = any_open ? S_IDLE : S_RELCK;
    end else if (lock_ev && state != S_ARMED) begin
      go_lock = 1'b1;
      tmr_clr = 1'b1;
      next_state = any_open ? S_IDLE : S_AWAIT;
    end else begin
      case (state)
        S_IDLE: begin
          next_state = S_IDLE;
        end
        S_AWAIT: begin
          if (ent_chg || key_s) begin
            next_state = S_IDLE;
          end else if (win_end) begin
            go_lock    = 1'b1;
            flash_n    = 2'h1;
            next_state = S_ARMED;
          end
        end
        S_RELCK: begin
          if (any_open || key_s) begin
            next_state = S_IDLE;
          end else if (win_end) begin
            go_lock    = 1'b1;
            flash_n    = 2'h1;
            next_state = S_ARMED;
          end
        end
        S_ARMED: begin
          if (key_ign) begin
            next_state = S_IDLE;
          end else if (any_open) begin
            next_state = S_ALARM;
            alm_go     = 1'b1;
            inh_set    = 1'b1;
          end else if (lock_ev) begin
            go_lock = 1'b1;
            flash_n = 2'h1;
          end
        end
        S_ALARM: begin
          if (ign_clear) begin
            inh_clr    = 1'b1;
            next_state = S_IDLE;
          end else if (trunk_ev) begin
            alm_go = 1'b1;
          end else if (alm_end) begin
            next_state = S_ADONE;
          end
        end
        S_ADONE: begin
          if (ign_clear) begin
            inh_clr    = 1'b1;
            next_state = S_IDLE;
          end else if (open_rise) begin
            next_state = S_ALARM;
            alm_go     = 1'b1;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  // Alarm length and cycle limit per variant
  wire [TMR_W-1:0] per_sel = (reg_v == REG_EUR) ? ALM_EUR_TK : ALM_GEN_TK;
  wire [1:0]       lim_sel = (reg_v == REG_CJ) ? CYC_CJ : CYC_NONE;
  wire [1:0]       bat_lim = (reg_v == REG_EUR) ? CYC_BAT_E : CYC_BAT;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state    <= S_BOOT;
      boot_cnt <= 2'h0;
      reg_v    <= REG_GEN;
      rkc_q    <= '0;
      ent_q    <= '0;
    end else begin
      state    <= next_state;
      boot_cnt <= boot_done ? boot_cnt : boot_cnt + 2'h1;
      if (state == S_BOOT) begin
        reg_v <= aas_region_t'(region_s);
      end
      rkc_q    <= rkc_s;
      ent_q    <= ent_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      win_tmr <= '0;
      ign_tmr <= '0;
    end else begin
      if (tmr_clr || next_state != state) begin
        win_tmr <= '0;
      end else if (tick && !win_end) begin
        win_tmr <= win_tmr + 9'h1;
      end
      if (!key_ign || !in_alarm) begin
        ign_tmr <= '0;
      end else if (tick && !ign_clear) begin
        ign_tmr <= ign_tmr + 9'h1;
      end
    end
  end

  // one toggle drives horn and hazard
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      alm_tmr    <= '0;
      alm_ph     <= 4'h0;
      alm_on     <= 1'b0;
      alm_cyc    <= 2'h0;
      alm_period <= ALM_GEN_TK;
      alm_lim    <= CYC_NONE;
    end else if (alm_go) begin
      alm_tmr    <= '0;
      alm_ph     <= 4'h0;
      alm_on     <= 1'b1;
      alm_cyc    <= 2'h0;
      alm_period <= alm_bat ? ALM_BAT_TK : per_sel;
      alm_lim    <= alm_bat ? bat_lim : lim_sel;
    end else if (state == S_ALARM) begin
      if (tick && !alm_end) begin
        alm_tmr <= alm_tmr + 9'h1;
      end
      if (alm_ph_end) begin
        alm_ph <= 4'h0;
        // No fresh on-phase on the period's last tick
        alm_on <= ~alm_on & ~alm_end & (alm_tmr < alm_period - 9'h1);
        if (alm_on) begin
          alm_cyc <= alm_cyc + 2'h1;
        end
      end else if (tick) begin
        alm_ph <= alm_ph + 4'h1;
      end
    end else begin
      alm_on <= 1'b0;
      alm_ph <= 4'h0;
    end
  end

  // Hazard flash sequencer for lock and unlock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flash_left <= 2'h0;
      flash_ph   <= 4'h0;
      haz_f      <= 1'b0;
    end else if (flash_n != 2'h0) begin
      flash_left <= flash_n;
      flash_ph   <= 4'h0;
      haz_f      <= 1'b1;
    end else if (flash_end) begin
      flash_ph <= 4'h0;
      if (haz_f) begin
        haz_f      <= 1'b0;
        flash_left <= flash_left - 2'h1;
      end else begin
        haz_f <= (flash_left != 2'h0);
      end
    end else if (tick && (haz_f || flash_left != 2'h0)) begin
      flash_ph <= flash_ph + 4'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      door_lock     <= 1'b0;
      door_unlock   <= 1'b0;
      hazard        <= 1'b0;
      horn          <= 1'b0;
      start_inhibit <= 1'b0;
      armed         <= 1'b0;
      retain_armed  <= 1'b0;
      retain_alarm  <= 1'b0;
    end else begin
      door_lock     <= go_lock;
      door_unlock   <= go_unlock;
      hazard        <= (state == S_ALARM) ? alm_on : haz_f;
      horn          <= (state == S_ALARM) & alm_on;
      if (inh_set) begin
        start_inhibit <= 1'b1;
      end else if (inh_clr) begin
        start_inhibit <= 1'b0;
      end
      armed         <= (state == S_ARMED);
      retain_armed  <= (state == S_ARMED);
      retain_alarm  <= (state == S_ALARM);
    end
  end

endmodule : aas_sequencer

// ---- logic/aas_pkg.sv ----
// Purpose: Shared constants and types for the anti-theft sequencer
// Assumes: 10 MHz mclk, 100 ms slow tick
// Notes:   All windows are counted in ticks
package aas_pkg;

  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned TICK_MS    = 100;
  localparam int unsigned TICK_CYC   = (TICK_MS * 1000000) / CLK_NS;

  localparam int unsigned WIN_MS     = 30000;
  localparam int unsigned ALM_GEN_MS = 30000;
  localparam int unsigned ALM_EUR_MS = 27000;
  localparam int unsigned IGN_CLR_MS = 30000;
  localparam int unsigned FLASH_MS   = 500;
  localparam int unsigned ALM_PH_MS  = 500;

  localparam int unsigned TMR_W      = 9;
  localparam logic [TMR_W-1:0] WIN_TK     = TMR_W'(WIN_MS / TICK_MS);
  localparam logic [TMR_W-1:0] ALM_GEN_TK = TMR_W'(ALM_GEN_MS / TICK_MS);
  localparam logic [TMR_W-1:0] ALM_EUR_TK = TMR_W'(ALM_EUR_MS / TICK_MS);
  localparam logic [TMR_W-1:0] IGN_TK     = TMR_W'(IGN_CLR_MS / TICK_MS);
  localparam logic [TMR_W-1:0] ALM_BAT_TK = 9'h1ff;
  localparam logic [3:0]       FLASH_TK   = 4'(FLASH_MS / TICK_MS);
  localparam logic [3:0]       ALM_PH_TK  = 4'(ALM_PH_MS / TICK_MS);

  localparam logic [1:0] CYC_CJ    = 2'h3;
  localparam logic [1:0] CYC_BAT   = 2'h3;
  localparam logic [1:0] CYC_BAT_E = 2'h1;
  localparam logic [1:0] CYC_NONE  = 2'h0;
  localparam logic [1:0] BOOT_CYC  = 2'h3;

  typedef enum logic [1:0] {
    REG_GEN = 2'b00,
    REG_CJ  = 2'b01,
    REG_EUR = 2'b10
  } aas_region_t;

  typedef enum logic [2:0] {
    S_BOOT  = 3'b000,
    S_IDLE  = 3'b001,
    S_AWAIT = 3'b010,
    S_RELCK = 3'b011,
    S_ARMED = 3'b100,
    S_ALARM = 3'b101,
    S_ADONE = 3'b110
  } aas_state_t;

  typedef struct packed {
    logic lock;
    logic unlock;
    logic trunk;
  } aas_rkc_t;

  typedef struct packed {
    logic door;
    logic hood;
    logic trunk;
  } aas_entry_t;

endpackage : aas_pkg

// ---- logic/aas_sync.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module aas_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : aas_sync

// ---- logic/aas_timebase.sv ----
// Purpose: Slow tick generator for second-scale timing
// Assumes: CYC mclk cycles per tick
// Notes:   Tick is a one-cycle pulse
`timescale 1ns/1ps
module aas_timebase #(
  parameter int unsigned CYC = 1000000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Tick
  output logic      tick
);
  logic [31:0] cnt;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else if (cnt == 32'(CYC - 1)) begin
      cnt  <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : aas_timebase

// ---- testbench/aas_seq_asserts.sv ----
// Purpose: Port checks for the anti-theft sequencer
// Assumes: Sees only the sequencer ports
// Notes:   Bound below the module
`timescale 1ns/1ps
module aas_seq_asserts
  import aas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // Inputs
  input wire aas_rkc_t   remote_keyless_command,
  input wire logic       key_in,
  input wire logic       ign_on,
  input wire aas_entry_t entry_open,
  input wire logic [1:0] region,
  input wire logic       nv_armed,
  input wire logic       nv_alarm,
  // Outputs
  input wire logic       door_lock,
  input wire logic       door_unlock,
  input wire logic       hazard,
  input wire logic       horn,
  input wire logic       start_inhibit,
  input wire logic       armed,
  input wire logic       retain_armed,
  input wire logic       retain_alarm
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_door_excl; !(door_lock && door_unlock); endproperty
  a_door_excl: assert property (p_door_excl)
    else $error("Lock and unlock pulses overlap");
  property p_lock_pulse; door_lock |=> !door_lock; endproperty
  a_lock_pulse: assert property (p_lock_pulse)
    else $error("Lock pulse longer than one cycle");
  property p_unlk_pulse; door_unlock |=> !door_unlock; endproperty
  a_unlk_pulse: assert property (p_unlk_pulse)
    else $error("Unlock pulse longer than one cycle");
  property p_horn_haz; horn |-> hazard; endproperty
  a_horn_haz: assert property (p_horn_haz)
    else $error("Horn on while hazard off");
  property p_unlk_disarm; door_unlock |-> ##[0:2] !armed; endproperty
  a_unlk_disarm: assert property (p_unlk_disarm)
    else $error("Still armed after unlock");
  property p_inh_alarm; $rose(start_inhibit) |-> ##[0:3] horn; endproperty
  a_inh_alarm: assert property (p_inh_alarm)
    else $error("Inhibit set without alarm");
  property p_inh_clr; $fell(start_inhibit) |-> $past(ign_on) && $past(key_in); endproperty
  a_inh_clr: assert property (p_inh_clr)
    else $error("Inhibit released without ignition");
  property p_armed_quiet; armed |-> !horn; endproperty
  a_armed_quiet: assert property (p_armed_quiet)
    else $error("Horn sounding while armed");
  property p_alarm_retain; horn |-> retain_alarm; endproperty
  a_alarm_retain: assert property (p_alarm_retain)
    else $error("Alarm not retained while sounding");

  c_unlock: cover property (door_unlock);
  c_arm: cover property ($rose(armed));
  c_alarm: cover property ($rose(horn));
endmodule : aas_seq_asserts

bind aas_sequencer aas_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk(mclk), .rstn(rstn), .remote_keyless_command(remote_keyless_command),
  .key_in(key_in), .ign_on(ign_on), .entry_open(entry_open), .region(region),
  .nv_armed(nv_armed), .nv_alarm(nv_alarm), .door_lock(door_lock),
  .door_unlock(door_unlock), .hazard(hazard), .horn(horn),
  .start_inhibit(start_inhibit), .armed(armed), .retain_armed(retain_armed),
  .retain_alarm(retain_alarm)
);

// ---- testbench/aas_vehicle_model.sv ----
// Purpose: Receiver, key switch and entry switches
// Assumes: Changes land on the falling edge
// Notes:   Buttons held long enough to sync
`timescale 1ns/1ps
module aas_vehicle_model
  import aas_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Pins to the sequencer
  output aas_rkc_t   rkc,
  output logic       key_in,
  output logic       ign_on,
  output aas_entry_t entry_open
);
  initial begin
    rkc = '0;
    key_in = 1'b0;
    ign_on = 1'b0;
    entry_open = '0;
  end
  // Press and release, low gap before next
  task automatic press(input int b);
    @(negedge mclk);
    rkc[b] = 1'b1;
    repeat (20) @(negedge mclk);
    rkc[b] = 1'b0;
    repeat (20) @(negedge mclk);
  endtask : press
  task automatic set_in(input logic k, input logic i, input aas_entry_t e);
    @(negedge mclk);
    key_in = k;
    ign_on = i;
    entry_open = e;
  endtask : set_in
endmodule : aas_vehicle_model

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the sequencer
// Assumes: Ten clock cycles per tick
// Notes:   Counts pulses and phases at the ports
`timescale 1ns/1ps
module testbench;
  import aas_pkg::*;
  localparam int unsigned TK = 10;
  localparam int WIN = 3300;
  localparam int B_LK = 2;
  localparam int B_UL = 1;
  localparam int B_TR = 0;
  localparam aas_entry_t DR = 3'b100;
  logic mclk, rstn, nv_armed, nv_alarm, key_in, ign_on, hz_q, hn_q;
  logic [1:0] region;
  aas_rkc_t rkc;
  aas_entry_t entry_open;
  logic door_lock, door_unlock, hazard, horn, start_inhibit, armed, r_arm, r_alm;
  int n_mismatch, total_checks, n_lk, n_ul, n_hz, n_hn, i;

  aas_vehicle_model vm (.mclk(mclk), .rkc(rkc), .key_in(key_in), .ign_on(ign_on),
    .entry_open(entry_open));
  aas_sequencer #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .rstn(rstn),
    .remote_keyless_command(rkc), .key_in(key_in), .ign_on(ign_on),
    .entry_open(entry_open), .region(region), .nv_armed(nv_armed),
    .nv_alarm(nv_alarm), .door_lock(door_lock), .door_unlock(door_unlock),
    .hazard(hazard), .horn(horn), .start_inhibit(start_inhibit), .armed(armed),
    .retain_armed(r_arm), .retain_alarm(r_alm));

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // Reference counts of pulses and lamp phases
  always @(posedge mclk) begin
    n_lk += int'(door_lock === 1'b1);
    n_ul += int'(door_unlock === 1'b1);
    n_hz += int'(hazard === 1'b1 && hz_q !== 1'b1);
    n_hn += int'(horn === 1'b1 && hn_q !== 1'b1);
    hz_q = hazard;
    hn_q = horn;
  end

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n
  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t output %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  task automatic clr;
    n_lk = 0;
    n_ul = 0;
    n_hz = 0;
    n_hn = 0;
  endtask : clr
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  task automatic boot(input logic [1:0] r, input logic a, input logic l);
    @(negedge mclk);
    rstn = 1'b0;
    region = r;
    nv_armed = a;
    nv_alarm = l;
    wt(6);
    clr();
    rstn = 1'b1;
    wt(20);
  endtask : boot

  initial begin
    #(90000 * 100);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    region = REG_GEN;
    nv_armed = 1'b0;
    nv_alarm = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    clr();
    void'($urandom(32'h2a016973));
    boot(REG_GEN, 1'b0, 1'b0);
    vm.press(B_UL);
    wt(400);
    chk_n(n_ul, 1);
    chk_n(n_hz, 2);
    wt(WIN - 400);
    chk_n(n_lk, 1);
    chk_n(n_hz, 3);
    chk_b(armed, 1'b1);
    // Alarm runs on with the door shut again
    clr();
    vm.set_in(1'b0, 1'b0, DR);
    wt(20);
    vm.set_in(1'b0, 1'b0, '0);
    chk_b(start_inhibit, 1'b1);
    wt(WIN);
    chk_n(n_hn, 30);
    chk_b(horn, 1'b0);
    clr();
    vm.set_in(1'b0, 1'b0, DR);
    wt(250);
    chk_n(n_hn, 3);
    vm.set_in(1'b1, 1'b1, DR);
    wt(1000);
    vm.set_in(1'b0, 1'b0, DR);
    clr();
    wt(200);
    chk_n(n_hn, 2);
    vm.set_in(1'b1, 1'b1, DR);
    wt(WIN);
    chk_b(start_inhibit, 1'b0);
    chk_b(horn, 1'b0);
    // Lock with an entry open
    vm.set_in(1'b0, 1'b0, DR);
    clr();
    vm.press(B_LK);
    wt(200);
    chk_n(n_lk, 1);
    chk_n(n_hz, 0);
    chk_b(armed, 1'b0);
    clr();
    vm.press(B_UL);
    wt(WIN);
    chk_n(n_lk, 0);
    chk_n(n_hz, 2);
    vm.set_in(1'b0, 1'b0, '0);
    clr();
    vm.press(B_UL);
    i = 100 + int'($urandom % 1500);
    wt(i);
    vm.set_in(1'b0, 1'b0, DR);
    wt(30);
    vm.set_in(1'b0, 1'b0, '0);
    wt(WIN - i);
    chk_n(n_lk, 0);
    chk_b(armed, 1'b0);
    clr();
    vm.press(B_UL);
    wt(2000);
    vm.press(B_UL);
    wt(1400);
    chk_n(n_lk, 0);
    chk_n(n_ul, 2);
    chk_n(n_hz, 4);
    wt(1900);
    chk_n(n_lk, 1);
    chk_b(armed, 1'b1);
    vm.set_in(1'b1, 1'b1, '0);
    wt(20);
    chk_b(armed, 1'b0);
    vm.set_in(1'b0, 1'b0, '0);
    // Shorter alarm variant and power return
    boot(REG_EUR, 1'b0, 1'b0);
    vm.press(B_LK);
    wt(WIN);
    chk_n(n_lk, 2);
    chk_n(n_hz, 1);
    chk_b(armed, 1'b1);
    clr();
    vm.set_in(1'b0, 1'b0, DR);
    wt(20);
    vm.set_in(1'b0, 1'b0, '0);
    wt(WIN);
    chk_n(n_hn, 27);
    boot(REG_EUR, 1'b0, 1'b1);
    wt(600);
    chk_n(n_hn, 1);
    boot(REG_GEN, 1'b0, 1'b1);
    wt(600);
    chk_n(n_hn, 3);
    chk_b(start_inhibit, 1'b1);
    boot(REG_CJ, 1'b1, 1'b0);
    chk_b(armed, 1'b1);
    chk_b(r_arm, 1'b1);
    // Lock while armed: pulse and one flash, stays armed
    clr();
    vm.press(B_LK);
    wt(100);
    chk_n(n_lk, 1);
    chk_n(n_hz, 1);
    chk_b(armed, 1'b1);
    clr();
    vm.set_in(1'b0, 1'b0, DR);
    wt(20);
    vm.set_in(1'b0, 1'b0, '0);
    for (i = 0; i < 2000 && n_hn < 2; i++) wt(1);
    chk_b(r_alm, 1'b1);
    for (i = 0; i < 200 && horn !== 1'b0; i++) wt(1);
    vm.press(B_TR);
    wt(120);
    chk_n(n_hn, 4);
    vm.press(B_LK);
    wt(100);
    chk_n(n_hn, 4);
    chk_b(horn, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
